/* core/crs_reset_sequencer.sv */
// reset sequencer: source gathering, pin filter, hold, strobes, start vector
`timescale 1ns/10ps
`include "crs_defs.svh"
// Functional notes
// (RULE1) four reset sources accepted: power-on, pin, watchdog, stop-mode recovery
// (RULE2) active reset overrides everything and puts the core in a known state
// (RULE3) outside party holds pin low at least 21 clocks or 5 crystal cycles
// (RULE4) power-on, pin, or run/halt watchdog resets restore control register defaults
// (RULE5) stop recovery or stop-mode watchdog keep control registers unchanged
// (RULE6) during pin reset address strobe toggles, data strobe low, read/write high
// (RULE7) reset loads program counter with 000Ch and defaults control state
// (RULE8) general-purpose registers are never touched by reset
// (RULE9) pin assertions shorter than four clocks are filtered out
// (RULE10) fifth clock latches reset, held 18 clocks or pin duration, longer wins
// (RULE11) fetch from 000Ch starts 5 to 10 clocks after release
// (RULE12) pin is sampled on the clock; four clocks reset circuitry after detection
// (RULE13) all sources merge into one request with the firing source recorded; the pin is not in otherReq and enters through the filter
module crs_reset_sequencer #(
  parameter int FETCH_DELAY = `CRS_FETCH_MIN
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // reset sources
  input wire logic powerOnReq,
  input wire logic resetPin_n,
  input wire logic watchdogTimeout,
  input wire logic stopRecovery,
  input wire logic inStopMode,
  // core control
  output logic coreReset,
  output logic ctrlDefaultLoad,
  output logic pcLoad,
  output logic [15:0] pcValue,
  output logic fetchStart,
  output crs_pkg::crs_src_t lastSource,
  // external memory strobes
  output logic address_strobe_n,
  output logic data_strobe_n,
  output logic readWrite
);
  import crs_pkg::*;
  typedef struct packed {
    crs_state_t state;
    logic pinHeld;
    logic defaults;
    crs_src_t src;
    logic coreReset;
    logic ctrlDefaultLoad;
    logic pcLoad;
    logic fetchStart;
    logic asN;
    logic dsN;
  } crs_st_t;
  crs_st_t st;
  crs_st_t next_st;
  logic [4:0] cnt;
  logic cntClear;
  logic pinLow;
  logic otherReq;
  initial begin
    if (FETCH_DELAY < `CRS_FETCH_MIN || FETCH_DELAY > `CRS_FETCH_MAX) $error("fetch delay out of range");
  end
  crs_counter #(.WIDTH(5)) uCnt (
    .sys_clk(sys_clk),
    .rst(rst),
    .clear(cntClear),
    .enable(1'b1),
    .count(cnt)
  );
  // pin is taken as synchronous to sys_clk
  assign pinLow = !resetPin_n; // RULE12
  assign otherReq = powerOnReq || watchdogTimeout || stopRecovery; // RULE1 RULE13
  always_comb begin
    next_st = st;
    cntClear = 1'b0;
    next_st.ctrlDefaultLoad = 1'b0;
    next_st.pcLoad = 1'b0;
    next_st.fetchStart = 1'b0;
    case (st.state)
      CRS_IDLE: begin
        cntClear = 1'b1;
        if (otherReq) begin
          // internal sources skip the pin filter
          next_st.state = CRS_HOLD; // RULE2
          next_st.pinHeld = 1'b0;
          if (powerOnReq) begin // RULE4
            next_st.src = CRS_SRC_POR;
            next_st.defaults = 1'b1;
          end else if (watchdogTimeout) begin // RULE5
            next_st.src = CRS_SRC_WDT;
            next_st.defaults = !inStopMode;
          end else begin
            next_st.src = CRS_SRC_STOP;
            next_st.defaults = 1'b0;
          end
        end else if (pinLow) begin
          next_st.state = CRS_FILT;
        end
      end
      CRS_FILT: begin
        if (!pinLow) begin
          next_st.state = CRS_IDLE; // RULE9
        end else if (cnt == 5'(`CRS_LATCH_CLK - 2)) begin
          // fifth clock since detection latches the reset
          cntClear = 1'b1;
          next_st.state = CRS_HOLD; // RULE10
          next_st.pinHeld = 1'b1;
          next_st.src = CRS_SRC_PIN;
          next_st.defaults = 1'b1; // RULE4
        end
      end
      CRS_HOLD: begin
        next_st.coreReset = 1'b1; // RULE2
        next_st.asN = !st.asN; // RULE6
        next_st.dsN = 1'b0; // RULE6
        next_st.pcLoad = 1'b1; // RULE7
        next_st.ctrlDefaultLoad = st.defaults; // RULE4 RULE5 RULE8
        if (cnt >= 5'(`CRS_HOLD_CLKS - 1) && !(st.pinHeld && pinLow)) begin
          cntClear = 1'b1;
          next_st.state = CRS_WAIT; // RULE10
        end
      end
      CRS_WAIT: begin
        next_st.coreReset = 1'b0;
        next_st.asN = 1'b1;
        next_st.dsN = 1'b1;
        if (cnt == 5'(FETCH_DELAY - 1)) begin
          next_st.state = CRS_FETCH;
          next_st.fetchStart = 1'b1; // RULE11
        end
      end
      CRS_FETCH: begin
        next_st.state = CRS_IDLE;
      end
      default: begin
        next_st.state = CRS_IDLE;
      end
    endcase
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st <= '{state: CRS_IDLE, pinHeld: 1'b0, defaults: 1'b1, src: CRS_SRC_POR,
              coreReset: 1'b1, ctrlDefaultLoad: 1'b0, pcLoad: 1'b0, fetchStart: 1'b0,
              asN: 1'b1, dsN: 1'b1};
    end else begin
      st <= next_st;
    end
  end
  assign coreReset = st.coreReset;
  assign ctrlDefaultLoad = st.ctrlDefaultLoad;
  assign pcLoad = st.pcLoad;
  assign pcValue = `CRS_START_VECTOR; // RULE7
  assign fetchStart = st.fetchStart;
  assign lastSource = st.src;
  assign address_strobe_n = st.asN;
  assign data_strobe_n = st.dsN;
  assign readWrite = 1'b1; // RULE6

  a_short_glitch: assert property (@(posedge sys_clk) disable iff (rst) // RULE9
    st.state == CRS_FILT && !pinLow |=> st.state == CRS_IDLE)
    else $error("short pin pulse started reset");
  a_fifth_latch: assert property (@(posedge sys_clk) disable iff (rst) // RULE10
    (st.state == CRS_IDLE && !otherReq && pinLow) ##1 pinLow [*4] |=> st.state == CRS_HOLD)
    else $error("reset not latched on fifth clock");
  a_hold_min: assert property (@(posedge sys_clk) disable iff (rst) // RULE10
    $rose(st.state == CRS_HOLD) |-> ##1 coreReset [*8] ##1 coreReset [*8] ##1 coreReset [*2])
    else $error("reset hold too short");
  a_hold_pin: assert property (@(posedge sys_clk) disable iff (rst) // RULE10
    st.state == CRS_HOLD && st.pinHeld && pinLow |=> st.state == CRS_HOLD)
    else $error("reset released while pin low");
  a_strobe_pattern: assert property (@(posedge sys_clk) disable iff (rst) // RULE6
    st.state == CRS_HOLD && $past(st.state) == CRS_HOLD |-> coreReset && !data_strobe_n && readWrite &&
      address_strobe_n != $past(address_strobe_n))
    else $error("strobe pattern wrong in reset");
  a_fetch_window: assert property (@(posedge sys_clk) disable iff (rst) // RULE11
    $fell(coreReset) |-> ##[4:9] fetchStart)
    else $error("fetch not in window");
  a_pc_vector: assert property (@(posedge sys_clk) disable iff (rst) // RULE7
    pcLoad |-> pcValue == 16'h000c && coreReset)
    else $error("bad start vector");
  a_stop_keep: assert property (@(posedge sys_clk) disable iff (rst) // RULE5
    st.state == CRS_IDLE && !powerOnReq && ((watchdogTimeout && inStopMode) || (!watchdogTimeout && stopRecovery))
      |-> ##2 !ctrlDefaultLoad [*8])
    else $error("defaults loaded after stop recovery");
  a_por_default: assert property (@(posedge sys_clk) disable iff (rst) // RULE4
    st.state == CRS_IDLE && powerOnReq |-> ##2 ctrlDefaultLoad && lastSource == CRS_SRC_POR)
    else $error("power-on did not load defaults");
  c_pin_reset: cover property (@(posedge sys_clk) disable iff (rst)
    st.state == CRS_FILT ##1 st.state == CRS_HOLD);
  c_glitch: cover property (@(posedge sys_clk) disable iff (rst)
    st.state == CRS_FILT ##1 st.state == CRS_IDLE);
  c_stop_wdt: cover property (@(posedge sys_clk) disable iff (rst)
    st.state == CRS_IDLE && watchdogTimeout && inStopMode);
  c_fetch: cover property (@(posedge sys_clk) disable iff (rst) fetchStart);
endmodule

/* core/crs_defs.svh */
// constants for the cpu reset sequencer
`ifndef CRS_DEFS_SVH
`define CRS_DEFS_SVH
`define CRS_START_VECTOR 16'h000c
`define CRS_FILTER_CLKS 4
`define CRS_LATCH_CLK 5
`define CRS_HOLD_CLKS 18
`define CRS_FETCH_MIN 5
`define CRS_FETCH_MAX 10
`define CRS_CIRCUIT_CLKS 4
`define CRS_MIN_HOLD_SCP 21
`endif

/* core/crs_pkg.sv */
// types for the cpu reset sequencer
package crs_pkg;
  typedef enum logic [2:0] {
    CRS_IDLE = 3'b000,
    CRS_FILT = 3'b001,
    CRS_HOLD = 3'b011,
    CRS_WAIT = 3'b010,
    CRS_FETCH = 3'b110
  } crs_state_t;
  typedef enum logic [1:0] {
    CRS_SRC_POR = 2'h0,
    CRS_SRC_PIN = 2'h1,
    CRS_SRC_WDT = 2'h2,
    CRS_SRC_STOP = 2'h3
  } crs_src_t;
endpackage

/* core/crs_counter.sv */
// saturating up counter with synchronous clear
`timescale 1ns/10ps
module crs_counter #(
  parameter int WIDTH = 5
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // control
  input wire logic clear,
  input wire logic enable,
  // count
  output logic [WIDTH-1:0] count
);
  typedef struct packed {
    logic [WIDTH-1:0] cnt;
  } crs_cnt_t;
  crs_cnt_t st;
  crs_cnt_t next_st;
  initial begin
    if (WIDTH < 4) $error("crs_counter width too small");
  end
  always_comb begin
    next_st = st;
    if (clear) begin
      next_st.cnt = '0;
    end else if (enable && st.cnt != {WIDTH{1'b1}}) begin
      next_st.cnt = st.cnt + 1'b1;
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign count = st.cnt;
endmodule

/* verification/crs_pin_source.sv */
// external reset circuit model: pulled-up pin, driven low for a commanded span
`timescale 1ns/10ps
module crs_pin_source (
  // clock
  input wire logic sys_clk,
  // command
  input wire logic go,
  input wire logic [7:0] lowLen,
  // pin
  output logic resetPin_n
);
  logic [7:0] left;
  initial left = 8'h00;
  always @(posedge sys_clk) begin
    if (go) begin
      left <= lowLen;
    end else if (left != 8'h00) begin
      left <= left - 8'h01;
    end
  end
  // pull-up wins once the span runs out
  assign resetPin_n = (left == 8'h00);
endmodule

/* verification/tb_top.sv */
// self-checking bench for the reset sequencer
`timescale 1ns/10ps
module tb_top;
  import crs_pkg::*;
  typedef struct packed {logic [2:0] req; logic stop; crs_src_t src; logic dfl;} crs_row_t;
  logic sys_clk, rst, powerOnReq, watchdogTimeout, stopRecovery, inStopMode, pinGo;
  logic prevDs, prevAs, dflSeen, pcSeen;
  logic [7:0] pinLen;
  logic resetPin_n, coreReset, ctrlDefaultLoad, pcLoad, fetchStart, address_strobe_n, data_strobe_n, readWrite;
  logic [15:0] pcValue;
  crs_src_t lastSource;
  int mismatches, num_checks, hiCnt, gap, fGap, bad, i;
  // request order is por, watchdog, stop recovery; several at once test priority
  crs_row_t rows [5] = '{'{3'b111, 1'b0, CRS_SRC_POR, 1'b1}, '{3'b011, 1'b0, CRS_SRC_WDT, 1'b1},
    '{3'b010, 1'b1, CRS_SRC_WDT, 1'b0}, '{3'b001, 1'b0, CRS_SRC_STOP, 1'b0}, '{3'b100, 1'b0, CRS_SRC_POR, 1'b1}};
  crs_reset_sequencer #(.FETCH_DELAY(7)) dut_u (.sys_clk(sys_clk), .rst(rst), .powerOnReq(powerOnReq),
    .resetPin_n(resetPin_n), .watchdogTimeout(watchdogTimeout), .stopRecovery(stopRecovery),
    .inStopMode(inStopMode), .coreReset(coreReset), .ctrlDefaultLoad(ctrlDefaultLoad), .pcLoad(pcLoad),
    .pcValue(pcValue), .fetchStart(fetchStart), .lastSource(lastSource), .address_strobe_n(address_strobe_n),
    .data_strobe_n(data_strobe_n), .readWrite(readWrite));
  crs_pin_source pin_u (.sys_clk(sys_clk), .go(pinGo), .lowLen(pinLen), .resetPin_n(resetPin_n));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // rst leaves core reset high while strobes idle, so the held span starts at the first low data strobe
  always @(posedge sys_clk) begin
    if (coreReset === 1'b1 && (data_strobe_n === 1'b0 || prevDs === 1'b0) && (data_strobe_n !== 1'b0
        || readWrite !== 1'b1 || address_strobe_n === prevAs)) bad++;
    if (coreReset === 1'b0 && (data_strobe_n !== 1'b1 || address_strobe_n !== 1'b1)) bad++;
    hiCnt += (coreReset === 1'b1 && data_strobe_n === 1'b0);
    gap = (coreReset === 1'b1) ? 0 : gap + 1;
    if (fetchStart === 1'b1) fGap = gap;
    dflSeen |= (ctrlDefaultLoad === 1'b1);
    pcSeen |= (pcLoad === 1'b1 && pcValue === 16'h000c);
    prevDs = data_strobe_n;
    prevAs = address_strobe_n;
  end
  task automatic chkVal(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic chkSpan(input int got, input int lo, input int hi, input string what);
    num_checks++;
    if (got < lo || got > hi) begin
      mismatches++;
      $display("[FAIL] %0t %s got %0d want %0d..%0d", $time, what, got, lo, hi);
    end
  endtask
  task automatic clearStats;
    hiCnt = 0;
    bad = 0;
    dflSeen = 1'b0;
    pcSeen = 1'b0;
    fGap = -1;
  endtask
  task automatic waitFetch;
    for (int n = 0; n < 300 && fGap < 0; n++) @(posedge sys_clk);
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic pinRun(input logic [7:0] len, input int lo, input int hi);
    @(posedge sys_clk);
    pinGo <= 1'b1;
    pinLen <= len;
    clearStats;
    @(posedge sys_clk);
    pinGo <= 1'b0;
    waitFetch;
    chkSpan(hiCnt, lo, hi, "pin hold");
    chkVal(lastSource, CRS_SRC_PIN, "pin source");
    chkVal(dflSeen, 1'b1, "pin defaults");
    chkSpan(bad, 0, 0, "pin strobes");
    chkSpan(fGap, 5, 10, "pin fetch");
    $display("test pin %0d done", len);
  endtask
  initial begin
    repeat (5000) @(posedge sys_clk);
    mismatches++;
    $display("[FAIL] %0t watchdog expired", $time);
    give_verdict;
  end
  initial begin
    rst = 1'b1;
    {powerOnReq, watchdogTimeout, stopRecovery, inStopMode, pinGo} = 5'h00;
    pinLen = 8'h00;
    gap = 0;
    clearStats;
    repeat (12) @(posedge sys_clk);
    chkVal(coreReset, 1'b1, "reset core");
    chkVal({address_strobe_n, data_strobe_n, readWrite, fetchStart}, 4'he, "reset outputs");
    chkVal(lastSource, CRS_SRC_POR, "reset source");
    rst <= 1'b0;
    $display("test reset done");
    for (i = 0; i < 5; i++) begin
      @(posedge sys_clk);
      {powerOnReq, watchdogTimeout, stopRecovery} <= rows[i].req;
      inStopMode <= rows[i].stop;
      clearStats;
      @(posedge sys_clk);
      {powerOnReq, watchdogTimeout, stopRecovery} <= 3'h0;
      waitFetch;
      chkVal(lastSource, rows[i].src, "source");
      chkVal(dflSeen, rows[i].dfl, "defaults");
      chkVal(pcSeen, 1'b1, "vector");
      chkSpan(bad, 0, 0, "strobes");
      chkSpan(hiCnt, 18, 20, "hold");
      chkSpan(fGap, 5, 10, "fetch");
      $display("test row %0d done", i);
    end
    inStopMode <= 1'b0;
    @(posedge sys_clk);
    pinGo <= 1'b1;
    pinLen <= 8'h03;
    clearStats;
    @(posedge sys_clk);
    pinGo <= 1'b0;
    repeat (30) @(posedge sys_clk);
    chkSpan(hiCnt, 0, 0, "short pin");
    $display("test short pin done");
    pinRun(8'd21, 18, 20);
    pinRun(8'd40, 34, 38);
    // reset dropped in the middle of a pin hold; the pin stays low past release
    @(posedge sys_clk);
    pinGo <= 1'b1;
    pinLen <= 8'd40;
    clearStats;
    @(posedge sys_clk);
    pinGo <= 1'b0;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chkVal(coreReset, 1'b1, "mid reset core");
    chkVal({address_strobe_n, data_strobe_n, readWrite, fetchStart}, 4'he, "mid reset outputs");
    chkVal(lastSource, CRS_SRC_POR, "mid reset source");
    rst <= 1'b0;
    clearStats;
    waitFetch;
    chkSpan(hiCnt, 21, 25, "mid reset hold");
    chkVal(lastSource, CRS_SRC_PIN, "mid reset pin");
    chkSpan(bad, 0, 0, "mid reset strobes");
    chkSpan(fGap, 5, 10, "mid reset fetch");
    $display("test mid reset done");
    give_verdict;
  end
endmodule
